// [shared/card_seq_pkg.sv]
package card_seq_pkg;

   // Card clock cycle counts, all measured in card clock periods
   localparam int unsigned CNT_W            = 17;
   localparam logic [16:0] DATA_HIGH_LIMIT  = 17'h0_00C8;  // 200
   localparam logic [16:0] ANSWER_MIN       = 17'h0_0190;  // 400
   localparam logic [16:0] ANSWER_MAX       = 17'h0_9C40;  // 40000
   localparam logic [16:0] RESET_LOW_CYCLES = 17'h0_9C40;  // 40000
   localparam logic [16:0] HIGH_HOLD_CYCLES = 17'h0_9C40;  // 40000
   localparam logic [16:0] CNT_ZERO         = 17'h0_0000;
   localparam logic [16:0] CNT_ONE          = 17'h0_0001;

   // Card clock divider: card clock = link clock / (2 * half period)
   localparam logic [3:0]  CLK_HALF_DIV     = 4'h4;
   localparam logic [3:0]  DIV_ONE          = 4'h1;
   localparam logic [3:0]  DIV_ZERO         = 4'h0;

   typedef enum {
      ST_IDLE,
      ST_LOW_WAIT,
      ST_ANSWER_WAIT,
      ST_HIGH_HOLD,
      ST_DONE
   } seq_state_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic answer_ok;
      logic no_data_high;
      logic early_answer;
      logic answer_timeout;
   } seq_status_t;

endpackage : card_seq_pkg

// [verilog/card_reset_sequencer.sv]
`timescale 1ns/1ns

// Functional notes
// R1 - After start, enable card clock; that instant is T0 for all counts.
// R2 - Internal-reset card drives data high within 200 card clocks of T0; not checked, no_data_high is set in ST_LOW_WAIT only.
// R3 - Internal-reset card answers between 400 and 40000 clocks after T0.
// R4 - Active-low card drives data high within 200 card clocks of T0.
// R5 - Hold card reset low at least 40000 card clocks from T0.
// R6 - Active-low card sends nothing while reset is held low; only an answer from cycle 200 on sets early_answer.
// R7 - After low period drive card reset high; that edge is T1.
// R8 - Keep card reset high at least 40000 card clocks after T1.
// R9 - Active-low card answers between 400 and 40000 clocks after T1.
// R10 - Count card clocks; flag missing, late or early answer.
module card_reset_sequencer
   import card_seq_pkg::*;
(
   input  wire logic        CLK_I,
   input  wire logic        SRST_I,
   input  wire logic        LINK_CLK_I,
   input  wire logic        START_I,
   input  wire logic        ACTIVE_LOW_I,
   output logic             CARD_CLOCK_OUT_O,
   output logic             CARD_RESET_OUT_O,
   input  wire logic        CARD_DATA_LINE_I,
   output logic             CARD_DATA_LINE_O,
   output logic             CARD_DATA_LINE_OE_O,
   output seq_status_t      STATUS_O
);

   ////////////////////////////////////////////////////////////////////////////
   // Host domain: start pulse becomes a toggle, link status returns as levels

   logic        start_tgl;
   logic        link_rst_req;
   seq_status_t link_status;
   seq_status_t stat_s1;
   seq_status_t stat_s2;

   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         start_tgl <= 1'b0;
      end else if (START_I) begin
         start_tgl <= ~start_tgl;
      end
   end

   // Reset is a level held across the crossing
   always_ff @(posedge CLK_I) begin
      link_rst_req <= SRST_I;
   end

   // Status bits are stable levels once set; a three-stage crossing suffices
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         stat_s1  <= '0;
         stat_s2  <= '0;
         STATUS_O <= '0;
      end else begin
         stat_s1  <= link_status;
         stat_s2  <= stat_s1;
         STATUS_O <= stat_s2;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link domain crossings

   logic       lrst_s1;
   logic       lrst;
   logic [2:0] tgl_sync;
   logic       tgl_seen;
   logic       start_ev;
   logic       mode_s1;
   logic       mode_s2;

   always_ff @(posedge LINK_CLK_I) begin
      lrst_s1 <= link_rst_req;
      lrst    <= lrst_s1;
   end

   always_ff @(posedge LINK_CLK_I) begin
      if (lrst) begin
         tgl_sync <= 3'h0;
         tgl_seen <= 1'b0;
      end else begin
         tgl_sync <= {tgl_sync[1:0], start_tgl};
         tgl_seen <= tgl_sync[2];
      end
   end

   assign start_ev = tgl_sync[2] ^ tgl_seen;

   // Mode is a static strap from the host side, sampled when a run starts
   always_ff @(posedge LINK_CLK_I) begin
      mode_s1 <= ACTIVE_LOW_I;
      mode_s2 <= mode_s1;
   end

   // Card data input: three stages, change accepted when last two agree
   logic [2:0] dat_sync;
   logic       dat;

   always_ff @(posedge LINK_CLK_I) begin
      if (lrst) begin
         dat_sync <= 3'h7;
         dat      <= 1'b1;
      end else begin
         dat_sync <= {dat_sync[1:0], CARD_DATA_LINE_I};
         if (dat_sync[2] == dat_sync[1]) begin
            dat <= dat_sync[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Card clock divider, running only while enabled

   logic       clk_en;
   logic [3:0] div;
   logic       card_tick;

   always_ff @(posedge LINK_CLK_I) begin
      if (lrst || !clk_en) begin
         div              <= DIV_ZERO;
         CARD_CLOCK_OUT_O <= 1'b0;
      end else if (div == CLK_HALF_DIV - DIV_ONE) begin
         div              <= DIV_ZERO;
         CARD_CLOCK_OUT_O <= ~CARD_CLOCK_OUT_O;
      end else begin
         div <= div + DIV_ONE;
      end
   end

   // One tick per card clock period, on its rising edge
   assign card_tick = clk_en && (div == CLK_HALF_DIV - DIV_ONE) && !CARD_CLOCK_OUT_O;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   seq_state_t       state;
   logic [CNT_W-1:0] cnt;
   logic             active_low;
   logic             answer_seen;
   logic             dat_prev;
   logic             answer_start;

   function automatic logic in_window(input logic [CNT_W-1:0] c);
      in_window = (c >= ANSWER_MIN) && (c <= ANSWER_MAX);
   endfunction : in_window

   // Start bit of the answer: falling edge on the data line
   assign answer_start = dat_prev && !dat;

   always_ff @(posedge LINK_CLK_I) begin
      if (lrst) begin
         dat_prev <= 1'b1;
      end else begin
         dat_prev <= dat;
      end
   end

   always_ff @(posedge LINK_CLK_I) begin
      if (lrst) begin
         state      <= ST_IDLE;
         clk_en     <= 1'b0;
         active_low <= 1'b0;
         cnt        <= CNT_ZERO;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_ev) begin
                  clk_en     <= 1'b1;  // [R1]
                  active_low <= mode_s2;
                  cnt        <= CNT_ZERO;
                  state      <= mode_s2 ? ST_LOW_WAIT : ST_ANSWER_WAIT;
               end
            end
            ST_LOW_WAIT: begin
               if (card_tick) begin
                  if (cnt == RESET_LOW_CYCLES - CNT_ONE) begin
                     cnt   <= CNT_ZERO;  // T1 [R7]
                     state <= ST_HIGH_HOLD;
                  end else begin
                     cnt <= cnt + CNT_ONE;  // [R5]
                  end
               end
            end
            ST_HIGH_HOLD: begin
               if (card_tick && cnt != HIGH_HOLD_CYCLES) begin
                  cnt <= cnt + CNT_ONE;  // [R8] [R10]
               end
               if (answer_seen && cnt >= HIGH_HOLD_CYCLES) begin
                  state <= ST_DONE;
               end else if (cnt >= HIGH_HOLD_CYCLES && link_status.answer_timeout) begin
                  state <= ST_DONE;
               end
            end
            ST_ANSWER_WAIT: begin
               if (card_tick && cnt != ANSWER_MAX) begin
                  cnt <= cnt + CNT_ONE;  // [R10]
               end
               if (answer_seen || link_status.answer_timeout || link_status.early_answer) begin
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               if (start_ev) begin
                  cnt        <= CNT_ZERO;
                  active_low <= mode_s2;
                  state      <= mode_s2 ? ST_LOW_WAIT : ST_ANSWER_WAIT;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Active-low card: reset output low from T0 until T1, high afterwards; internal-reset card: held low throughout
   always_ff @(posedge LINK_CLK_I) begin
      if (lrst) begin
         CARD_RESET_OUT_O <= 1'b0;
      end else if (state == ST_IDLE || state == ST_LOW_WAIT) begin
         CARD_RESET_OUT_O <= 1'b0;  // [R5]
      end else if (state == ST_HIGH_HOLD || active_low) begin
         CARD_RESET_OUT_O <= 1'b1;  // [R7] [R8]
      end else begin
         CARD_RESET_OUT_O <= 1'b0;
      end
   end

   // The device only listens on the data line during the reset sequence
   assign CARD_DATA_LINE_O    = 1'b0;
   assign CARD_DATA_LINE_OE_O = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Answer checks; flags hold until the next start

   logic in_answer_phase;
   logic early_data_low;

   assign in_answer_phase = (state == ST_ANSWER_WAIT) || (state == ST_HIGH_HOLD);
   assign early_data_low  = (state == ST_LOW_WAIT || state == ST_ANSWER_WAIT)
                            && (cnt >= DATA_HIGH_LIMIT) && !dat;

   always_ff @(posedge LINK_CLK_I) begin
      if (lrst || start_ev) begin
         link_status <= '0;
         answer_seen <= 1'b0;
      end else begin
         link_status.busy <= (state != ST_IDLE) && (state != ST_DONE);
         link_status.done <= (state == ST_DONE);
         // Data line must be high after 200 cycles; checked only while reset is held low [R4]
         if (early_data_low && state == ST_LOW_WAIT) begin
            link_status.no_data_high <= 1'b1;
         end
         if (in_answer_phase && !answer_seen && answer_start) begin
            answer_seen <= 1'b1;
            if (in_window(cnt)) begin
               link_status.answer_ok <= 1'b1;  // [R3] [R9]
            end else begin
               link_status.early_answer <= 1'b1;  // [R10]
            end
         end
         // An answer starting from cycle 200 on while reset is low is a card fault [R6]
         if (state == ST_LOW_WAIT && answer_start && cnt >= DATA_HIGH_LIMIT) begin
            link_status.early_answer <= 1'b1;
         end
         if (in_answer_phase && !answer_seen && cnt >= ANSWER_MAX) begin
            link_status.answer_timeout <= 1'b1;  // [R10]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_low_done;
      (state == ST_LOW_WAIT) && card_tick && (cnt == RESET_LOW_CYCLES - CNT_ONE);
   endsequence

   a_reset_low_hold: assert property (@(posedge LINK_CLK_I) disable iff (lrst) // [R5]
      (state == ST_LOW_WAIT) |-> ##1 !CARD_RESET_OUT_O)
      else $error("card reset rose during the low period");

   a_t1_rise: assert property (@(posedge LINK_CLK_I) disable iff (lrst) // [R7]
      s_low_done |-> ##2 CARD_RESET_OUT_O)
      else $error("card reset not raised at T1");

   a_high_hold: assert property (@(posedge LINK_CLK_I) disable iff (lrst) // [R8]
      (state == ST_HIGH_HOLD) && (cnt < HIGH_HOLD_CYCLES) |-> ##1 (state == ST_HIGH_HOLD))
      else $error("high hold left early");

   a_clock_on: assert property (@(posedge LINK_CLK_I) disable iff (lrst) // [R1]
      (state == ST_IDLE) && start_ev |=> clk_en && (cnt == CNT_ZERO))
      else $error("card clock not enabled at start");

   a_answer_flag: assert property (@(posedge LINK_CLK_I) disable iff (lrst || start_ev) // [R10]
      in_answer_phase && !answer_seen && answer_start && !in_window(cnt)
      |=> link_status.early_answer)
      else $error("out of window answer not flagged");

endmodule : card_reset_sequencer

// [tb/card_model.sv]
`timescale 1ns/1ns

// Behavioural card: counts its own clock edges from T0 and, for an active-low
// card, from the rise of its reset (T1)
module card_model (
   input  wire logic        card_clk_i,
   input  wire logic        card_rst_i,
   input  wire logic        arm_i,
   input  wire logic        active_low_i,
   input  wire logic [16:0] high_at_i,
   input  wire logic [16:0] answer_at_i,
   output logic             oe_o,
   output logic             val_o
);
   logic [16:0] since_t0;
   logic [16:0] since_t1;
   logic [16:0] ref_cnt;

   always @(posedge card_clk_i or negedge arm_i) begin
      if (!arm_i)
         since_t0 <= 17'h0_0000;
      else
         since_t0 <= since_t0 + 17'h0_0001;
   end

   always @(posedge card_clk_i or negedge arm_i or negedge card_rst_i) begin
      if (!arm_i || !card_rst_i)
         since_t1 <= 17'h0_0000;
      else
         since_t1 <= since_t1 + 17'h0_0001;
   end

   assign ref_cnt = active_low_i ? since_t1 : since_t0;

   ////////////////////////////////////////////////////////////////////////////
   // Start bit lasts 8 card clocks; outside it the card drives the line low until high_at_i clocks after T0, then high
   always_comb begin
      oe_o  = arm_i;
      val_o = (since_t0 >= high_at_i);
      if (ref_cnt >= answer_at_i && ref_cnt < answer_at_i + 17'h0_0008 &&
          (!active_low_i || card_rst_i))
         val_o = 1'b0;
   end
endmodule : card_model

// [tb/tb_card_reset_sequencer.sv]
`timescale 1ns/1ns

module tb_card_reset_sequencer;
   import card_seq_pkg::*;
   logic        clk, srst, link_clk, start, active_low, arm;
   logic        card_clk, card_rst, dat_o, dat_oe, card_oe, card_val;
   wire logic   line;
   seq_status_t status;
   logic [16:0] high_at, answer_at;
   logic [16:0] hi_t [3];
   logic [16:0] ans_t [3];
   logic [3:0]  ex_t [3];
   logic [3:0]  exp_q [$];
   logic [7:0]  lfsr;
   int          failures, compares;

   // Pull-up on the data line wins whenever nobody drives it
   assign line = dat_oe ? dat_o : (card_oe ? card_val : 1'b1);

   card_reset_sequencer i_card_reset_sequencer (
      .CLK_I(clk), .SRST_I(srst), .LINK_CLK_I(link_clk), .START_I(start),
      .ACTIVE_LOW_I(active_low), .CARD_CLOCK_OUT_O(card_clk), .CARD_RESET_OUT_O(card_rst),
      .CARD_DATA_LINE_I(line), .CARD_DATA_LINE_O(dat_o), .CARD_DATA_LINE_OE_O(dat_oe),
      .STATUS_O(status));

   card_model i_card_model (
      .card_clk_i(card_clk), .card_rst_i(card_rst), .arm_i(arm), .active_low_i(active_low),
      .high_at_i(high_at), .answer_at_i(answer_at), .oe_o(card_oe), .val_o(card_val));

   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next

   task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic print_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////////////////////
   // A fresh reset before each sequence avoids depending on restart from ST_DONE
   task automatic run_seq(input logic al, input logic [16:0] hi, input logic [16:0] ans);
      @(posedge clk);
      srst       <= 1'b1;
      arm        <= 1'b0;
      active_low <= al;
      high_at    <= hi;
      answer_at  <= ans;
      repeat (16) @(posedge clk);
      check("clock idle", 4'h0, {3'h0, card_clk});
      srst <= 1'b0;
      arm  <= 1'b1;
      repeat (9) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask : run_seq

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      link_clk = 1'b0;
      #3;
      forever #6 link_clk = ~link_clk;
   end

   // Flags are synchronised bit by bit, so let them all settle before comparing
   initial begin
      forever begin
         @(posedge (status.answer_ok | status.early_answer | status.answer_timeout));
         repeat (4) @(posedge clk);
         if (exp_q.size() == 0)
            check("unexpected result", 4'h0, status[3:0]);
         else
            check("status flags", exp_q.pop_front(), status[3:0]);
      end
   end

   initial begin
      #360000;
      failures++;
      $display("ERROR watchdog expected 0 seen 1");
      print_verdict();
   end

   initial begin
      int i;
      int n;
      // Arm starts high so the first run_seq makes a real falling edge for the card
      srst = 1'b1; start = 1'b0; active_low = 1'b0; arm = 1'b1;
      high_at = 17'h0_0000; answer_at = 17'h0_0000; failures = 0; compares = 0;
      lfsr = 8'h3B;
      lfsr = lfsr_next(lfsr);
      hi_t[0] = 17'h0_0064; ans_t[0] = 17'h0_01C2 + {9'h0_00, lfsr}; ex_t[0] = 4'h8;
      hi_t[1] = 17'h0_0064; ans_t[1] = 17'h0_012C; ex_t[1] = 4'h2;
      // Late data-high is only flagged while reset is held low, not for this card kind
      hi_t[2] = 17'h0_00FA; ans_t[2] = 17'h0_0258; ex_t[2] = 4'h8;
      repeat (4) @(posedge clk);
      for (i = 0; i < 3; i++) begin
         run_seq(1'b0, hi_t[i], ans_t[i]);
         exp_q.push_back(ex_t[i]);
         for (n = 0; n < 40000 && exp_q.size() != 0; n++)
            @(posedge clk);
         check("result seen", 4'h0, {3'h0, exp_q.size() != 0});
         repeat (8) @(posedge clk);
         check("done busy", 4'h2, {2'h0, status.done, status.busy});
         exp_q.delete();
         $display("test %0d done", i);
      end
      // Card raises data late on purpose, so the low-phase check must flag it
      run_seq(1'b1, 17'h0_00FA, 17'h0_01F4);
      repeat (1000) @(posedge card_clk);
      check("late data high", 4'h4, status[3:0]);
      check("card reset low", 4'h0, {3'h0, card_rst});
      check("busy", 4'h1, {3'h0, status.busy});
      check("data oe", 4'h0, {3'h0, dat_oe});
      $display("test 3 done");
      print_verdict();
   end
endmodule : tb_card_reset_sequencer
